/* dcbf_fifo.sv */
`timescale 1ns/10ps
// Summary of operation
// - Clear input held low returns write and read pointers to location zero.
// - After clear, full and almost-full flags read high.
// - After clear, empty and almost-empty flags read low.
// - Clear zeroes every bit of the output register.
// - Write and read data paths are eight bits wide.
// - Writes start on write clock rising edges; full flags change only there.
// - Write enable low at a write edge captures the input byte.
// - Bytes are stored in arrival order, independent of reads.
// - Write enable high leaves the input register unchanged.
// - Full flag low; write enable ignored so nothing overflows.
// - After a read on a full queue, full releases at a write edge.
// - Read data moves on read edges; empty flags change only there.
// - Read enable low at a read edge loads the next byte out.
// - Read enable high leaves the output register unchanged.
// - All data read: empty flag low, read enable ignored.
// - After a write into an empty queue, empty releases at a read edge.
// - Output enable low drives the bus; high releases it.
// - Works with unrelated or identical write and read clocks.
// - Empty flag asserts when no words remain stored.
// - Full flag asserts when stored count equals depth.
// - Almost-full asserts while count is within seven of depth.
// - Almost-empty low while at most seven words are stored.
module dcbf_fifo
  import dcbf_pkg::*;
#(
  parameter int DEPTH = DEPTH_DEF
) (
  input  wire logic              core_clk,
  input  wire logic              rst,
  input  wire logic              clear_n,
  input  wire logic              write_clk,
  input  wire logic              write_en_n,
  input  wire logic [DATA_W-1:0] write_data,
  input  wire logic              read_clk,
  input  wire logic              read_en_n,
  input  wire logic              output_en_n,
  output logic [DATA_W-1:0]      read_data,
  output logic                   read_data_oe_n,
  output logic                   full_flag_n,
  output logic                   almost_full_n,
  output logic                   empty_flag_n,
  output logic                   almost_empty_n
);

  // ****************************************************************
  // Sizes and elaboration checks
  // ****************************************************************
  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;
  localparam logic [CW-1:0] FULL_CNT  = CW'(DEPTH);
  localparam logic [CW-1:0] AFULL_CNT = CW'(DEPTH - AF_MARGIN);
  localparam logic [CW-1:0] AEMPTY_CNT = CW'(AE_LEVEL);
  localparam logic [CW-1:0] ZERO_CNT  = '0;

  if ((DEPTH < 16) || ((1 << AW) != DEPTH)) begin : g_bad_depth
    $error("dcbf_fifo: depth must be a power of two of at least 16");
  end

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    dcbf_wpin_s                   wp_s1;
    dcbf_wpin_s                   wp_s2;
    dcbf_wpin_s                   wp_d;
    dcbf_rpin_s                   rp_s1;
    dcbf_rpin_s                   rp_s2;
    dcbf_rpin_s                   rp_d;
    logic                         clr_s1;
    logic                         clr_s2;
    logic [DATA_W-1:0]            in_reg;
    logic [DEPTH-1:0][DATA_W-1:0] mem;
    logic [CW-1:0]                wr_ptr;
    logic [CW-1:0]                rd_ptr;
    logic [CW-1:0]                cnt;
    dcbf_flags_s                  flags;
    logic [DATA_W-1:0]            out_data;
    logic                         out_oe_n;
  } dcbf_st_s;

  dcbf_st_s          st_r;
  dcbf_st_s          st_nxt;
  logic              clr_act;
  logic              wr_edge;
  logic              rd_edge;
  logic              wr_go;
  logic              rd_go;
  logic              arr_valid;
  logic              skid_in_ready;
  logic              skid_out_valid;
  logic [DATA_W-1:0] skid_out_data;
  logic              prefetch;
  logic [CW-1:0]     cnt_nxt;

  // ****************************************************************
  // Events seen on the synchronised pins
  // ****************************************************************
  // Rising edges found after two sync stages; enables come from the sample before
  assign clr_act  = ~st_r.clr_s2;
  assign wr_edge  = st_r.wp_s2.clk & ~st_r.wp_d.clk;
  assign rd_edge  = st_r.rp_s2.clk & ~st_r.rp_d.clk;
  // Writes refused while the full flag is low
  assign wr_go    = wr_edge & ~st_r.wp_d.en_n & st_r.flags.full_n & ~clr_act;
  // Reads refused while the empty flag is low
  assign rd_go    = rd_edge & ~st_r.rp_d.en_n & st_r.flags.empty_n & skid_out_valid
                    & ~clr_act;
  // Array head moves into the buffer whenever the buffer has room
  assign arr_valid = (st_r.wr_ptr != st_r.rd_ptr);
  assign prefetch  = arr_valid & skid_in_ready & ~clr_act;
  // Count of words held anywhere in the queue
  assign cnt_nxt   = st_r.cnt + CW'(wr_go) - CW'(rd_go);

  // ****************************************************************
  // Prefetch buffer between array and output register
  // ****************************************************************
  dcbf_skid #(
    .W         (DATA_W)
  ) u_skid (
    .core_clk  (core_clk),
    .rst       (rst),
    .flush     (clr_act),
    .in_valid  (arr_valid),
    .in_ready  (skid_in_ready),
    .in_data   (st_r.mem[st_r.rd_ptr[AW-1:0]]),
    .out_valid (skid_out_valid),
    .out_ready (rd_go),
    .out_data  (skid_out_data)
  );

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    st_nxt = st_r;
    // Pin synchronisers, single clock for both ports
    st_nxt.wp_s1  = '{clk: write_clk, en_n: write_en_n, data: write_data};
    st_nxt.wp_s2  = st_r.wp_s1;
    st_nxt.wp_d   = st_r.wp_s2;
    st_nxt.rp_s1  = '{clk: read_clk, en_n: read_en_n, oe_n: output_en_n};
    st_nxt.rp_s2  = st_r.rp_s1;
    st_nxt.rp_d   = st_r.rp_s2;
    st_nxt.clr_s1 = clear_n;
    st_nxt.clr_s2 = st_r.clr_s1;
    // Output drive follows the output enable
    st_nxt.out_oe_n = st_r.rp_s2.oe_n;
    // Write port: capture and store in order
    if (wr_go) begin
      st_nxt.in_reg = st_r.wp_d.data;
      st_nxt.mem[st_r.wr_ptr[AW-1:0]] = st_r.wp_d.data;
      st_nxt.wr_ptr = st_r.wr_ptr + CW'(1);
    end
    // Array head into the prefetch buffer
    if (prefetch) begin
      st_nxt.rd_ptr = st_r.rd_ptr + CW'(1);
    end
    st_nxt.cnt = cnt_nxt;
    // Read port: load the next byte into the output register
    if (rd_go) begin
      st_nxt.out_data = skid_out_data;
    end
    // Write-side flags change only at write edges
    if (wr_edge) begin
      st_nxt.flags.full_n  = (cnt_nxt != FULL_CNT);
      st_nxt.flags.afull_n = (cnt_nxt < AFULL_CNT);
    end
    // Read-side flags change only at read edges
    if (rd_edge) begin
      st_nxt.flags.empty_n  = (cnt_nxt != ZERO_CNT);
      st_nxt.flags.aempty_n = (cnt_nxt > AEMPTY_CNT);
    end
    // Clear pin held low
    if (clr_act) begin
      st_nxt.wr_ptr   = '0;
      st_nxt.rd_ptr   = '0;
      st_nxt.cnt      = '0;
      st_nxt.flags    = FLAGS_RST;
      st_nxt.out_data = OUT_DATA_RST;
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_r          <= '0;
      st_r.wp_s1    <= WPIN_RST;
      st_r.wp_s2    <= WPIN_RST;
      st_r.wp_d     <= WPIN_RST;
      st_r.rp_s1    <= RPIN_RST;
      st_r.rp_s2    <= RPIN_RST;
      st_r.rp_d     <= RPIN_RST;
      st_r.clr_s1   <= CLR_SYNC_RST;
      st_r.clr_s2   <= CLR_SYNC_RST;
      st_r.flags    <= FLAGS_RST;
      st_r.out_data <= OUT_DATA_RST;
      st_r.out_oe_n <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************************************
  // Outputs, all straight from flip-flops
  // ****************************************************************
  assign read_data      = st_r.out_data;
  assign read_data_oe_n = st_r.out_oe_n;
  assign full_flag_n    = st_r.flags.full_n;
  assign almost_full_n  = st_r.flags.afull_n;
  assign empty_flag_n   = st_r.flags.empty_n;
  assign almost_empty_n = st_r.flags.aempty_n;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  // Pointers sit at zero after a clear
  ptr_clear_a: assert property (st_r.clr_s2 == 1'b0 |=> st_r.wr_ptr == '0 && st_r.rd_ptr == '0)
    else $error("pointers not zero after clear");

  // Write-side flags high after a clear
  wflag_clear_a: assert property (st_r.clr_s2 == 1'b0 |=> full_flag_n && almost_full_n)
    else $error("write flags not high after clear");

  // Read-side flags low after a clear
  rflag_clear_a: assert property (st_r.clr_s2 == 1'b0 |=> !empty_flag_n && !almost_empty_n)
    else $error("read flags not low after clear");

  // Output register zero after a clear
  out_clear_a: assert property (st_r.clr_s2 == 1'b0 |=> read_data == 8'h00)
    else $error("output register not zero after clear");

  // Full flag moves only after a write edge
  full_edge_a: assert property ($changed(full_flag_n) |-> $past(wr_edge) || $past(clr_act))
    else $error("full flag changed without a write edge");

  // Empty flag moves only after a read edge
  empty_edge_a: assert property ($changed(empty_flag_n) |-> $past(rd_edge) || $past(clr_act))
    else $error("empty flag changed without a read edge");

  // Stored byte lands at the write pointer
  wr_store_a: assert property (wr_go |=> st_r.mem[$past(st_r.wr_ptr[AW-1:0])]
                                         == $past(st_r.wp_d.data) && st_r.in_reg
                                         == $past(st_r.wp_d.data))
    else $error("written byte not stored");

  // Input register holds without an accepted write
  in_hold_a: assert property (!wr_go |=> $stable(st_r.in_reg))
    else $error("input register changed without a write");

  // A write while full leaves the write pointer alone
  no_ovf_a: assert property (wr_edge && !full_flag_n && !clr_act |=>
                             $stable(st_r.wr_ptr))
    else $error("write accepted while full");

  // Count never exceeds the depth
  cnt_bound_a: assert property (st_r.cnt <= FULL_CNT)
    else $error("occupancy above depth");

  // Read loads the buffer head into the output register
  rd_load_a: assert property (rd_go |=> read_data == $past(skid_out_data))
    else $error("read did not load next byte");

  // Output register holds without an accepted read
  out_hold_a: assert property (!rd_go && !clr_act |=> $stable(read_data))
    else $error("output register changed without a read");

  // Empty flag follows the count at read edges
  empty_cnt_a: assert property (rd_edge && !clr_act |=> empty_flag_n == ($past(cnt_nxt) != '0))
    else $error("empty flag wrong at read edge");

  // Full and almost-full follow the count at write edges
  full_cnt_a: assert property (wr_edge && !clr_act |=> full_flag_n == ($past(cnt_nxt) != FULL_CNT)
                               && almost_full_n == ($past(cnt_nxt) < AFULL_CNT))
    else $error("write flags wrong at write edge");

  // Almost-empty follows the count at read edges
  aempty_cnt_a: assert property (rd_edge && !clr_act |=>
                                 almost_empty_n == ($past(cnt_nxt) > AEMPTY_CNT))
    else $error("almost-empty flag wrong at read edge");

  // Empty flag never reads high with nothing stored
  no_false_a: assert property (empty_flag_n |-> st_r.cnt != '0)
    else $error("empty flag released with nothing stored");

  // Output drive tracks the output enable three samples later
  oe_track_a: assert property (read_data_oe_n == $past(st_r.rp_s2.oe_n))
    else $error("output enable not followed");

  // Full flag never reads high with the queue full
  full_lie_a: assert property (full_flag_n |-> st_r.cnt != FULL_CNT)
    else $error("full flag released with the queue full");

  // Almost-full never reads high above its threshold
  afull_lie_a: assert property (almost_full_n |-> st_r.cnt < AFULL_CNT)
    else $error("almost-full flag released above threshold");

  // Almost-empty never reads high at or below its threshold
  aempty_lie_a: assert property (almost_empty_n |-> st_r.cnt > AEMPTY_CNT)
    else $error("almost-empty flag released at or below threshold");

  // Almost-full moves only after a write edge
  afull_edge_a: assert property ($changed(almost_full_n) |->
                                 $past(wr_edge) || $past(clr_act))
    else $error("almost-full flag changed without a write edge");

  // Almost-empty moves only after a read edge
  aempty_edge_a: assert property ($changed(almost_empty_n) |->
                                  $past(rd_edge) || $past(clr_act))
    else $error("almost-empty flag changed without a read edge");

  // Each accepted write moves the write pointer by one
  wr_step_a: assert property (wr_go |=> st_r.wr_ptr == $past(st_r.wr_ptr) + CW'(1))
    else $error("write pointer did not step by one");

  // Each prefetch moves the read pointer by one
  rd_step_a: assert property (prefetch |=> st_r.rd_ptr == $past(st_r.rd_ptr) + CW'(1))
    else $error("read pointer did not step by one");

  // A read edge while empty leaves the output register alone
  no_udf_a: assert property (rd_edge && !empty_flag_n && !clr_act |=>
                             $stable(read_data))
    else $error("read accepted while empty");

  // Empty flag releases at the first read edge with words stored
  empty_rel_a: assert property (rd_edge && !clr_act && !empty_flag_n &&
                                st_r.cnt != ZERO_CNT |=> empty_flag_n)
    else $error("empty flag not released after a write");

  // Full flag releases at the first write edge after a read
  full_rel_a: assert property (wr_edge && !clr_act && !full_flag_n &&
                               st_r.cnt != FULL_CNT |=> full_flag_n)
    else $error("full flag not released after a read");

  // Clear empties the prefetch buffer too
  clr_flush_a: assert property (clr_act |=> !skid_out_valid)
    else $error("prefetch buffer not emptied by clear");

  // Main scenarios
  full_reach_c: cover property (!full_flag_n);
  same_edge_c:  cover property (wr_go && rd_go);
  drain_c:      cover property (rd_go && cnt_nxt == '0);
  full_rel_c:   cover property (!full_flag_n ##1 full_flag_n);

endmodule

/* dcbf_pkg.sv */
// ****************************************************************
// Shared constants and carrier types for the byte queue
// ****************************************************************
package dcbf_pkg;

  // ****************************************************************
  // Sizes and flag thresholds
  // ****************************************************************
  localparam int DATA_W     = 8;   // Width of both data paths
  localparam int DEPTH_DEF  = 64;  // Default storage depth
  localparam int AE_LEVEL   = 7;   // Almost empty while count is at most this
  localparam int AF_MARGIN  = 7;   // Almost full while count is within this of depth
  localparam int CORE_CLK_PERIOD_NS = 100;  // Core clock period

  // ****************************************************************
  // Carrier types
  // ****************************************************************
  // Sampled write-side pins
  typedef struct packed {
    logic              clk;
    logic              en_n;
    logic [DATA_W-1:0] data;
  } dcbf_wpin_s;

  // Sampled read-side pins
  typedef struct packed {
    logic clk;
    logic en_n;
    logic oe_n;
  } dcbf_rpin_s;

  // Status flags, all active low
  typedef struct packed {
    logic full_n;
    logic afull_n;
    logic aempty_n;
    logic empty_n;
  } dcbf_flags_s;

  // Occupancy of the two-entry buffer, Gray coded
  typedef enum logic [1:0] {
    SK_EMPTY = 2'h0,
    SK_ONE   = 2'h1,
    SK_TWO   = 2'h3
  } dcbf_skid_e;

  // ****************************************************************
  // Values after reset
  // ****************************************************************
  localparam dcbf_wpin_s  WPIN_RST  = '{clk: 1'b1, en_n: 1'b1, data: 8'h00};
  localparam dcbf_rpin_s  RPIN_RST  = '{clk: 1'b1, en_n: 1'b1, oe_n: 1'b1};
  localparam dcbf_flags_s FLAGS_RST = '{full_n: 1'b1, afull_n: 1'b1,
                                        aempty_n: 1'b0, empty_n: 1'b0};
  localparam logic [DATA_W-1:0] OUT_DATA_RST = 8'h00;
  localparam logic              CLR_SYNC_RST = 1'b1;

endpackage

/* dcbf_skid.sv */
`timescale 1ns/10ps
// ****************************************************************
// Two-entry buffer with valid and ready on both sides
// ****************************************************************
module dcbf_skid
  import dcbf_pkg::*;
#(
  parameter int W = DATA_W
) (
  input  wire logic         core_clk,
  input  wire logic         rst,
  input  wire logic         flush,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);

  if (W < 1) begin : g_bad_width
    $error("dcbf_skid: width must be at least one");
  end

  typedef struct packed {
    dcbf_skid_e   state;
    logic [W-1:0] head;
    logic [W-1:0] tail;
  } dcbf_skid_st_s;

  dcbf_skid_st_s st_r;
  dcbf_skid_st_s st_nxt;
  logic          push;
  logic          pop;

  // Handshake terms
  assign in_ready  = (st_r.state != SK_TWO);
  assign out_valid = (st_r.state != SK_EMPTY);
  assign out_data  = st_r.head;
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // Next occupancy and contents
  always_comb begin
    st_nxt = st_r;
    unique case (st_r.state)
      SK_EMPTY: begin
        if (push) begin
          st_nxt.head  = in_data;
          st_nxt.state = SK_ONE;
        end
      end
      SK_ONE: begin
        if (push && pop) begin
          st_nxt.head = in_data;
        end else if (push) begin
          st_nxt.tail  = in_data;
          st_nxt.state = SK_TWO;
        end else if (pop) begin
          st_nxt.state = SK_EMPTY;
        end
      end
      SK_TWO: begin
        if (pop) begin
          st_nxt.head  = st_r.tail;
          st_nxt.state = SK_ONE;
        end
      end
      default: begin
        st_nxt.state = SK_EMPTY;
      end
    endcase
    if (flush) begin
      st_nxt.state = SK_EMPTY;
    end
  end

  // State register
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule

/* dcbf_peer.sv */
`timescale 1ns/10ps
// ****************************************************************
// Producer and consumer logic on the pin side of the byte queue
// ****************************************************************
module dcbf_peer
  import dcbf_pkg::*;
(
  input  wire logic         core_clk,
  output logic              write_clk,
  output logic              write_en_n,
  output logic [DATA_W-1:0] write_data,
  output logic              read_clk,
  output logic              read_en_n
);
  // Pins idle with clocks low and both ports disabled
  initial begin
    write_clk  = 1'b0;
    write_en_n = 1'b1;
    write_data = 8'h00;
    read_clk   = 1'b0;
    read_en_n  = 1'b1;
  end

  // Wait some core edges, then step just off the edge
  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // One pin clock cycle on either or both ports, three core cycles a phase
  task automatic cyc(input logic wen_n, input logic [DATA_W-1:0] d, input logic ren_n,
                     input logic do_w, input logic do_r);
    write_en_n = wen_n;
    write_data = d;
    read_en_n  = ren_n;
    idle(3);
    write_clk = do_w;
    read_clk  = do_r;
    idle(3);
    write_clk  = 1'b0;
    read_clk   = 1'b0;
    write_en_n = 1'b1;
    read_en_n  = 1'b1;
    write_data = ~d;  // Released bus shows no stale byte
    idle(3);
  endtask
endmodule

/* tb.sv */
`timescale 1ns/10ps
// ****************************************************************
// Self-checking bench for the byte queue
// ****************************************************************
module tb
  import dcbf_pkg::*;
;
  localparam int DEPTH = 16;

  logic              core_clk;
  logic              rst;
  logic              clear_n;
  logic              output_en_n;
  logic              write_clk;
  logic              write_en_n;
  logic [DATA_W-1:0] write_data;
  logic              read_clk;
  logic              read_en_n;
  logic [DATA_W-1:0] read_data;
  logic              read_data_oe_n;
  logic              full_flag_n;
  logic              almost_full_n;
  logic              empty_flag_n;
  logic              almost_empty_n;
  logic [3:0]        fl;
  wire  [DATA_W-1:0] q_bus;
  int                error_cnt;
  int                checks;

  // Three-state output bus and flag bundle
  assign q_bus = read_data_oe_n ? 8'hZZ : read_data;
  assign fl    = {full_flag_n, almost_full_n, almost_empty_n, empty_flag_n};

  // Core clock, 100 ns period
  always #50 core_clk = ~core_clk;

  dcbf_peer peer (
    .core_clk   (core_clk),
    .write_clk  (write_clk),
    .write_en_n (write_en_n),
    .write_data (write_data),
    .read_clk   (read_clk),
    .read_en_n  (read_en_n)
  );

  dcbf_fifo #(.DEPTH(DEPTH)) dut (
    .core_clk       (core_clk),
    .rst            (rst),
    .clear_n        (clear_n),
    .write_clk      (write_clk),
    .write_en_n     (write_en_n),
    .write_data     (write_data),
    .read_clk       (read_clk),
    .read_en_n      (read_en_n),
    .output_en_n    (output_en_n),
    .read_data      (read_data),
    .read_data_oe_n (read_data_oe_n),
    .full_flag_n    (full_flag_n),
    .almost_full_n  (almost_full_n),
    .empty_flag_n   (empty_flag_n),
    .almost_empty_n (almost_empty_n)
  );

  // ****************************************************************
  // Compare and report helpers
  // ****************************************************************
  function automatic logic [7:0] pat(input int k);
    return {k[3:0], ~k[3:0]};
  endfunction

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_flags(input logic [3:0] got, input logic [3:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: flags %h expected %h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset();
    chk_flags(fl, 4'hC);
    chk_byte(q_bus, 8'h00);
    $display("test reset done");
  endtask

  // Almost-empty boundary at seven and eight words
  task automatic t_fill_low();
    for (int k = 0; k < 7; k++)
      peer.cyc(1'b0, pat(k), 1'b1, 1'b1, 1'b0);
    peer.cyc(1'b1, 8'h00, 1'b1, 1'b0, 1'b1);
    chk_flags(fl, 4'hD);
    peer.cyc(1'b0, pat(7), 1'b1, 1'b1, 1'b0);
    peer.cyc(1'b1, 8'h00, 1'b1, 1'b0, 1'b1);
    chk_flags(fl, 4'hF);
    chk_byte(q_bus, 8'h00);
    $display("test low fill done");
  endtask

  // Fill to the top, then one refused write
  task automatic t_fill_high();
    for (int k = 8; k < DEPTH; k++) begin
      peer.cyc(1'b0, pat(k), 1'b1, 1'b1, 1'b0);
      chk_flags(fl & 4'hC, {k + 1 < DEPTH, k + 1 < DEPTH - AF_MARGIN, 2'b00});
    end
    peer.cyc(1'b0, 8'hEE, 1'b1, 1'b1, 1'b0);
    chk_flags(fl, 4'h3);
    $display("test high fill done");
  endtask

  // Drain in order, release of full, refused read when empty
  task automatic t_drain();
    peer.cyc(1'b1, 8'h00, 1'b0, 1'b0, 1'b1);
    chk_byte(q_bus, pat(0));
    peer.cyc(1'b1, 8'h00, 1'b1, 1'b1, 1'b0);
    chk_flags(fl & 4'hC, 4'h8);
    for (int k = 1; k < DEPTH; k++) begin
      peer.cyc(1'b1, 8'h00, 1'b0, 1'b0, 1'b1);
      chk_byte(q_bus, pat(k));
    end
    chk_flags(fl & 4'h3, 4'h0);
    peer.cyc(1'b1, 8'h00, 1'b0, 1'b0, 1'b1);
    chk_byte(q_bus, pat(DEPTH - 1));
    $display("test drain done");
  endtask

  task automatic t_oe();
    output_en_n = 1'b1;
    peer.idle(4);
    chk_byte(q_bus, 8'hZZ);
    output_en_n = 1'b0;
    peer.idle(4);
    chk_byte(q_bus, pat(DEPTH - 1));
    $display("test output enable done");
  endtask

  // Write and read clocks rising together
  task automatic t_same_clk();
    peer.cyc(1'b0, 8'h5A, 1'b1, 1'b1, 1'b1);
    peer.cyc(1'b0, 8'hA5, 1'b1, 1'b1, 1'b1);
    peer.cyc(1'b1, 8'h00, 1'b0, 1'b1, 1'b1);
    chk_byte(q_bus, 8'h5A);
    peer.cyc(1'b1, 8'h00, 1'b0, 1'b1, 1'b1);
    chk_byte(q_bus, 8'hA5);
    chk_flags(fl & 4'h1, 4'h0);
    $display("test same clock done");
  endtask

  // Clear in mid-run returns pointers and flags
  task automatic t_clear();
    for (int k = 0; k < 3; k++)
      peer.cyc(1'b0, pat(k), 1'b1, 1'b1, 1'b0);
    peer.cyc(1'b1, 8'h00, 1'b1, 1'b0, 1'b1);
    chk_flags(fl, 4'hD);
    clear_n = 1'b0;
    peer.idle(4);
    clear_n = 1'b1;
    peer.idle(4);
    chk_flags(fl, 4'hC);
    chk_byte(q_bus, 8'h00);
    peer.cyc(1'b0, 8'h3C, 1'b1, 1'b1, 1'b0);
    peer.cyc(1'b1, 8'h00, 1'b1, 1'b0, 1'b1);
    peer.cyc(1'b1, 8'h00, 1'b0, 1'b0, 1'b1);
    chk_byte(q_bus, 8'h3C);
    $display("test clear done");
  endtask

  // Main sequence
  initial begin
    core_clk    = 1'b0;
    rst         = 1'b1;
    clear_n     = 1'b1;
    output_en_n = 1'b0;
    error_cnt   = 0;
    checks      = 0;
    repeat (6) @(posedge core_clk);
    #1;
    rst = 1'b0;
    peer.idle(4);
    t_reset();
    t_fill_low();
    t_fill_high();
    t_drain();
    t_oe();
    t_same_clk();
    t_clear();
    summarize();
  end

  // Watchdog well beyond the expected run of about 460 core cycles
  initial begin
    #(5000 * CORE_CLK_PERIOD_NS);
    error_cnt++;
    summarize();
  end
endmodule
